/* File: hw/i2c_scl_consts.svh */
// Functional notes
// [R01] standard high count, 16 bits, resets 0x40
// [R02] standard low count, 16 bits, resets 0x4B
// [R03] fast high count, 16 bits, resets 0x0A
// [R04] fast low count, 16 bits, resets 0x15
// [R05] high-speed high count, resets 0x01
// [R06] high-speed low count, resets 0x07
// [R07] count writes ignored while interface enabled
// [R08] high-speed prefix phase uses fast counts
// [R09] software programs counts before any transaction
// [R10] bits 31:16 reserved, read zero; the status register returns the rising-edge count in bits 31:16
// [R11] master clocks SCL by counting cycles
`ifndef I2C_SCL_CONSTS_SVH
`define I2C_SCL_CONSTS_SVH

`define SCL_ADDR_W          8
`define SCL_OFS_STD_HIGH    8'h14
`define SCL_OFS_STD_LOW     8'h18
`define SCL_OFS_FAST_HIGH   8'h1C
`define SCL_OFS_FAST_LOW    8'h20
`define SCL_OFS_HS_HIGH     8'h24
`define SCL_OFS_HS_LOW      8'h28
`define SCL_OFS_STATUS      8'h40

`define SCL_RST_STD_HIGH    16'h0040
`define SCL_RST_STD_LOW     16'h004B
`define SCL_RST_FAST_HIGH   16'h000A
`define SCL_RST_FAST_LOW    16'h0015
`define SCL_RST_HS_HIGH     16'h0001
`define SCL_RST_HS_LOW      16'h0007

`define SCL_MIN_COUNT       16'h0001

`define SCL_SPEED_STD       2'h1
`define SCL_SPEED_FAST      2'h2
`define SCL_SPEED_HS        2'h3

`define SCL_SET_STD         2'h0
`define SCL_SET_FAST        2'h1
`define SCL_SET_HS          2'h2

`define SCL_ST_ENABLED      0
`define SCL_ST_SET_LO       1
`define SCL_ST_SET_HI       2
`define SCL_ST_LEVEL        3
`define SCL_ST_DRIVING      4
`define SCL_ST_LOCKED       5
`define SCL_ST_EDGE_LO      16
`define SCL_ST_EDGE_HI      31

`endif

/* File: hw/i2c_scl_pkg.sv */
package i2c_scl_pkg;

  typedef logic [15:0] count_t;

  typedef enum logic [1:0] {
    GEN_IDLE,
    GEN_LOW,
    GEN_WAIT_HIGH,
    GEN_HIGH
  } gen_state_e;

  typedef struct packed {
    gen_state_e state;
    count_t     count;
    logic       drive;
  } gen_s;

  typedef struct packed {
    logic        sclMeta;
    logic        sclSync;
    logic        sclPrev;
    count_t      stdHigh;
    count_t      stdLow;
    count_t      fastHigh;
    count_t      fastLow;
    count_t      hsHigh;
    count_t      hsLow;
    logic        lockedWrite;
    count_t      edgeCount;
    logic [31:0] rdData;
  } regs_s;

endpackage

/* File: hw/scl_period_gen.sv */
`include "i2c_scl_consts.svh"

module scl_period_gen (
  input  wire logic               core_clk,
  input  wire logic               reset,
  input  wire logic               run,
  input  wire i2c_scl_pkg::count_t highCount,
  input  wire i2c_scl_pkg::count_t lowCount,
  input  wire logic               sclLevel,
  output logic                    sclDrive,
  output i2c_scl_pkg::gen_state_e phase
);

  i2c_scl_pkg::gen_s cur;
  i2c_scl_pkg::gen_s next_cur;
  i2c_scl_pkg::count_t highLoad;
  i2c_scl_pkg::count_t lowLoad;

  // a zero count already ends the phase after one cycle; it is also raised to one here
  assign highLoad = (highCount < `SCL_MIN_COUNT) ? `SCL_MIN_COUNT : highCount;
  assign lowLoad  = (lowCount < `SCL_MIN_COUNT) ? `SCL_MIN_COUNT : lowCount;

  always_comb begin
    next_cur = cur;
    case (cur.state)
      i2c_scl_pkg::GEN_IDLE: begin
        next_cur.drive = 1'b0;
        if (run) begin
          next_cur.state = i2c_scl_pkg::GEN_LOW;
          next_cur.count = lowLoad;  // [R11]
          next_cur.drive = 1'b1;
        end
      end
      i2c_scl_pkg::GEN_LOW: begin
        if (cur.count <= `SCL_MIN_COUNT) begin
          next_cur.state = i2c_scl_pkg::GEN_WAIT_HIGH;
          next_cur.drive = 1'b0;
        end else begin
          next_cur.count = cur.count - `SCL_MIN_COUNT;  // [R11]
        end
      end
      i2c_scl_pkg::GEN_WAIT_HIGH: begin
        // high time starts only once the wire is seen high: a slave may stretch
        next_cur.drive = 1'b0;
        if (sclLevel) begin
          next_cur.state = i2c_scl_pkg::GEN_HIGH;
          next_cur.count = highLoad;  // [R11]
        end
      end
      i2c_scl_pkg::GEN_HIGH: begin
        if (cur.count > `SCL_MIN_COUNT) begin
          next_cur.count = cur.count - `SCL_MIN_COUNT;  // [R11]
        end else if (run) begin
          next_cur.state = i2c_scl_pkg::GEN_LOW;
          next_cur.count = lowLoad;
          next_cur.drive = 1'b1;
        end else begin
          next_cur.state = i2c_scl_pkg::GEN_IDLE;
        end
      end
      default: begin
        next_cur.state = i2c_scl_pkg::GEN_IDLE;
        next_cur.drive = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cur.state <= i2c_scl_pkg::GEN_IDLE;
      cur.count <= 16'h0000;
      cur.drive <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  assign sclDrive = cur.drive;
  assign phase    = cur.state;

endmodule

/* File: hw/i2c_scl_period_counts.sv */
// Chosen here: the strobed register port.
`include "i2c_scl_consts.svh"

module i2c_scl_period_counts (
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  // register port
  input  wire logic [`SCL_ADDR_W-1:0] regAddr,
  input  wire logic [31:0]            regWrData,
  input  wire logic                    regWrite,
  input  wire logic                    regRead,
  output logic      [31:0]            regRdData,
  // controller side
  input  wire logic                    interfaceEnabled,
  input  wire logic [1:0]             speedMode,
  input  wire logic                    masterActive,
  input  wire logic                    prefixPhase,
  // serial clock pin, open drain
  input  wire logic                    sclIn,
  output logic                         sclOut,
  output logic                         sclOe
);

  i2c_scl_pkg::regs_s cur;
  i2c_scl_pkg::regs_s next_cur;

  logic                    writeOpen;
  logic                    genRun;
  logic [1:0]              countSet;
  i2c_scl_pkg::count_t     selHigh;
  i2c_scl_pkg::count_t     selLow;
  logic                    genDrive;
  logic [31:0]             statusWord;
  logic [31:0]             readMux;
  logic                    sclRise;
  logic                    lockedHit;

  // -------------------------------------------------------------------
  // choice of count set
  // -------------------------------------------------------------------
  always_comb begin
    countSet = `SCL_SET_STD;
    case (speedMode)
      `SCL_SPEED_STD: begin
        countSet = `SCL_SET_STD;
      end
      `SCL_SPEED_FAST: begin
        countSet = `SCL_SET_FAST;
      end
      `SCL_SPEED_HS: begin
        // master code, start byte and general call go out at fast rate
        if (prefixPhase) begin
          countSet = `SCL_SET_FAST;  // [R08]
        end else begin
          countSet = `SCL_SET_HS;
        end
      end
      default: begin
        // unused encoding falls back to the slowest, safest timing
        countSet = `SCL_SET_STD;
      end
    endcase
  end

  always_comb begin
    selHigh = cur.stdHigh;
    selLow  = cur.stdLow;
    case (countSet)
      `SCL_SET_STD: begin
        selHigh = cur.stdHigh;  // [R11]
        selLow  = cur.stdLow;
      end
      `SCL_SET_FAST: begin
        selHigh = cur.fastHigh;  // [R08]
        selLow  = cur.fastLow;
      end
      `SCL_SET_HS: begin
        selHigh = cur.hsHigh;
        selLow  = cur.hsLow;
      end
      default: begin
        selHigh = cur.stdHigh;
        selLow  = cur.stdLow;
      end
    endcase
  end

  // the generator runs only as master on an enabled interface
  assign genRun = masterActive & interfaceEnabled;  // [R11]

  scl_period_gen u_gen (
    .core_clk  (core_clk),
    .reset     (reset),
    .run       (genRun),
    .highCount (selHigh),
    .lowCount  (selLow),
    .sclLevel  (cur.sclSync),
    .sclDrive  (genDrive),
    .phase     ()
  );

  // -------------------------------------------------------------------
  // register access
  // -------------------------------------------------------------------
  // counts are frozen while enabled so a running transfer keeps its timing
  assign writeOpen = ~interfaceEnabled;  // [R07]

  assign lockedHit = regWrite & interfaceEnabled &
                     ((regAddr == `SCL_OFS_STD_HIGH)  |
                      (regAddr == `SCL_OFS_STD_LOW)   |
                      (regAddr == `SCL_OFS_FAST_HIGH) |
                      (regAddr == `SCL_OFS_FAST_LOW)  |
                      (regAddr == `SCL_OFS_HS_HIGH)   |
                      (regAddr == `SCL_OFS_HS_LOW));

  assign sclRise = cur.sclSync & ~cur.sclPrev;

  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`SCL_ST_ENABLED] = interfaceEnabled;
    statusWord[`SCL_ST_SET_HI:`SCL_ST_SET_LO] = countSet;
    statusWord[`SCL_ST_LEVEL]   = cur.sclSync;
    statusWord[`SCL_ST_DRIVING] = genDrive;
    statusWord[`SCL_ST_LOCKED]  = cur.lockedWrite;
    statusWord[`SCL_ST_EDGE_HI:`SCL_ST_EDGE_LO] = cur.edgeCount;
  end

  always_comb begin
    readMux = 32'h0000_0000;
    case (regAddr)
      `SCL_OFS_STD_HIGH: begin
        readMux = {16'h0000, cur.stdHigh};  // [R10]
      end
      `SCL_OFS_STD_LOW: begin
        readMux = {16'h0000, cur.stdLow};  // [R10]
      end
      `SCL_OFS_FAST_HIGH: begin
        readMux = {16'h0000, cur.fastHigh};  // [R10]
      end
      `SCL_OFS_FAST_LOW: begin
        readMux = {16'h0000, cur.fastLow};  // [R10]
      end
      `SCL_OFS_HS_HIGH: begin
        readMux = {16'h0000, cur.hsHigh};  // [R10]
      end
      `SCL_OFS_HS_LOW: begin
        readMux = {16'h0000, cur.hsLow};  // [R10]
      end
      `SCL_OFS_STATUS: begin
        readMux = statusWord;
      end
      default: begin
        readMux = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    next_cur = cur;

    // pin sampling: the first stage feeds only the second
    next_cur.sclMeta = sclIn;
    next_cur.sclSync = cur.sclMeta;
    next_cur.sclPrev = cur.sclSync;

    // rising edges seen on the wire, free running and wrapping
    if (sclRise) begin
      next_cur.edgeCount = cur.edgeCount + 16'h0001;
    end

    // read data stand in the cycle after the strobe only
    if (regRead) begin
      next_cur.rdData = readMux;
    end else begin
      next_cur.rdData = 32'h0000_0000;
    end

    if (regWrite && writeOpen) begin
      case (regAddr)
        `SCL_OFS_STD_HIGH: begin
          next_cur.stdHigh = regWrData[15:0];  // [R01]
        end
        `SCL_OFS_STD_LOW: begin
          next_cur.stdLow = regWrData[15:0];  // [R02]
        end
        `SCL_OFS_FAST_HIGH: begin
          next_cur.fastHigh = regWrData[15:0];  // [R03]
        end
        `SCL_OFS_FAST_LOW: begin
          next_cur.fastLow = regWrData[15:0];  // [R04]
        end
        `SCL_OFS_HS_HIGH: begin
          next_cur.hsHigh = regWrData[15:0];  // [R05]
        end
        `SCL_OFS_HS_LOW: begin
          next_cur.hsLow = regWrData[15:0];  // [R06]
        end
        default: begin
          next_cur.stdHigh = cur.stdHigh;
        end
      endcase
    end

    // sticky flag for a refused count write; a new refusal beats the clear
    if (regWrite && (regAddr == `SCL_OFS_STATUS) && regWrData[`SCL_ST_LOCKED]) begin
      next_cur.lockedWrite = 1'b0;
    end
    if (lockedHit) begin
      next_cur.lockedWrite = 1'b1;  // [R07]
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cur.sclMeta     <= 1'b1;
      cur.sclSync     <= 1'b1;
      cur.sclPrev     <= 1'b1;
      cur.stdHigh     <= `SCL_RST_STD_HIGH;   // [R01]
      cur.stdLow      <= `SCL_RST_STD_LOW;    // [R02]
      cur.fastHigh    <= `SCL_RST_FAST_HIGH;  // [R03]
      cur.fastLow     <= `SCL_RST_FAST_LOW;   // [R04]
      cur.hsHigh      <= `SCL_RST_HS_HIGH;    // [R05]
      cur.hsLow       <= `SCL_RST_HS_LOW;     // [R06]
      cur.lockedWrite <= 1'b0;
      cur.edgeCount   <= 16'h0000;
      cur.rdData      <= 32'h0000_0000;
    end else begin
      cur <= next_cur;
    end
  end

  // open drain: only ever pulls low
  assign regRdData = cur.rdData;
  assign sclOe     = genDrive;
  assign sclOut    = 1'b0;

endmodule

/* File: test/i2c_scl_period_counts_properties.sv */
`include "i2c_scl_consts.svh"

module i2c_scl_period_counts_properties (
  input wire logic                   core_clk,
  input wire logic                   reset,
  input wire logic [`SCL_ADDR_W-1:0] regAddr,
  input wire logic                   regWrite,
  input wire logic                   regRead,
  input wire logic [31:0]            regRdData,
  input wire logic                   interfaceEnabled,
  input wire logic                   masterActive,
  input wire logic                   sclIn,
  input wire logic                   sclOut,
  input wire logic                   sclOe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence s_locked_wr;
    regWrite && interfaceEnabled && regAddr[1:0] == 2'h0
      && regAddr >= `SCL_OFS_STD_HIGH && regAddr <= `SCL_OFS_HS_LOW;
  endsequence
  sequence s_status_rd;
    regRead && regAddr == `SCL_OFS_STATUS;
  endsequence

  a_locked_flag: assert property (s_locked_wr ##1 s_status_rd |=> regRdData[5])
    else $error("refused write not flagged");
  a_status_bits: assert property (s_status_rd |=>
    regRdData[0] == $past(interfaceEnabled) && regRdData[4] == $past(sclOe))
    else $error("status bits wrong");
  a_read_zero: assert property (!$past(regRead) |-> regRdData == 32'h0)
    else $error("read data outside read cycle");
  a_reserved_zero: assert property ($past(regRead) && $past(regAddr) != `SCL_OFS_STATUS
    |-> regRdData[31:16] == 16'h0)
    else $error("reserved bits not zero");
  a_open_drain: assert property (sclOut == 1'b0)
    else $error("scl driven high");
  a_release_low: assert property ($fell(sclOe) |-> !sclOe [*3])
    else $error("high phase too short");
  a_rise_after_high: assert property ($rose(sclOe) |-> $past(sclIn))
    else $error("pulled low before scl seen high");
  a_stretch_hold: assert property (!sclIn && !sclOe |=> !sclOe [*2])
    else $error("stretch ignored");
  a_start_cause: assert property ($rose(sclOe) |-> $past(interfaceEnabled && masterActive))
    else $error("scl started without run");
endmodule

bind i2c_scl_period_counts i2c_scl_period_counts_properties i_props (
  .core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWrite(regWrite),
  .regRead(regRead), .regRdData(regRdData), .interfaceEnabled(interfaceEnabled),
  .masterActive(masterActive), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe));

/* File: test/i2c_bus_device.sv */
module i2c_bus_device (
  input  wire logic       core_clk,
  input  wire logic       sclOe,
  input  wire logic [7:0] stretch,
  output logic            sclIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] hold = 8'h00;
  logic       prevOe = 1'b0;
  logic       pullLow;
  // stretches right after the master lets go, so the wire never glitches high
  assign pullLow = hold != 8'h00 || (prevOe && !sclOe && stretch != 8'h00);
  // pull-up: released wire reads high
  assign sclIn = !(sclOe || pullLow);
  always @(posedge core_clk) begin
    prevOe <= sclOe;
    if (prevOe && !sclOe && stretch != 8'h00) begin
      hold <= stretch - 8'h01;
    end else if (hold != 8'h00) begin
      hold <= hold - 8'h01;
    end
  end
endmodule

/* File: test/testbench.sv */
`include "i2c_scl_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   core_clk = 1'b0;
  logic                   reset = 1'b1;
  logic [`SCL_ADDR_W-1:0] regAddr = 8'h00;
  logic [31:0]            regWrData = 32'h0;
  logic                   regWrite = 1'b0;
  logic                   regRead = 1'b0;
  logic [31:0]            regRdData;
  logic                   interfaceEnabled = 1'b0;
  logic [1:0]             speedMode = 2'h1;
  logic                   masterActive = 1'b0;
  logic                   prefixPhase = 1'b0;
  logic                   sclIn;
  logic                   sclOut;
  logic                   sclOe;
  logic [7:0]             stretch = 8'h00;
  logic [31:0]            d;
  int                     err_count = 0;
  int                     checks_done = 0;
  int                     cycles = 0;
  logic [7:0]  ofs [6] = '{8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28};
  logic [15:0] rst [6] = '{16'h0040, 16'h004B, 16'h000A, 16'h0015, 16'h0001, 16'h0007};
  logic [31:0] cnt [6] = '{32'h3, 32'h4, 32'h5, 32'h6, 32'h1, 32'h2};

  always #10 core_clk = ~core_clk;

  i2c_scl_period_counts i_i2c_scl_period_counts (
    .core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .interfaceEnabled(interfaceEnabled), .speedMode(speedMode),
    .masterActive(masterActive), .prefixPhase(prefixPhase), .sclIn(sclIn),
    .sclOut(sclOut), .sclOe(sclOe));
  i2c_bus_device i_i2c_bus_device (
    .core_clk(core_clk), .sclOe(sclOe), .stretch(stretch), .sclIn(sclIn));

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic t_regs();
    // idle after reset: wire seen high, no edges, nothing refused
    rd(8'h40);
    check(d, 32'h0000_0008);
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i]);
      check(d, {16'h0, rst[i]});
      wr(ofs[i], 32'hFFFF0000 | (i * 32'h111 + 32'h5));
      rd(ofs[i]);
      check(d, i * 32'h111 + 32'h5);
    end
    rd(8'h30);
    check(d, 32'h0);
  endtask

  task automatic t_locked();
    @(posedge core_clk);
    interfaceEnabled <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= 8'h14;
    regWrData <= 32'h0000BEEF;
    // status read straight after the refused write
    @(posedge core_clk);
    regWrite <= 1'b0;
    regRead <= 1'b1;
    regAddr <= 8'h40;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 check(32'(regRdData[5]), 32'h1);
    rd(8'h14);
    check(d, 32'h5);
    @(posedge core_clk);
    interfaceEnabled <= 1'b0;
    wr(8'h40, 32'h20);
    rd(8'h40);
    check(32'(d[5]), 32'h0);
  endtask

  task automatic t_period(input logic [1:0] m, input logic p, input int l, input int h,
                          input logic [7:0] s, input logic [1:0] set);
    int n;
    int k;
    n = 0;
    k = 0;
    @(posedge core_clk);
    speedMode <= m;
    prefixPhase <= p;
    stretch <= s;
    interfaceEnabled <= 1'b1;
    masterActive <= 1'b1;
    while (sclOe !== 1'b1 && k < 100) begin
      k++;
      @(posedge core_clk);
      #1;
    end
    do begin
      n++;
      @(posedge core_clk);
      #1;
    end while (sclOe === 1'b1 && n < 300);
    check(32'(n), 32'(l));
    n = 0;
    do begin
      n++;
      @(posedge core_clk);
      #1;
    end while (sclOe === 1'b0 && n < 300);
    // synchroniser and the wait state add three cycles before the high count starts
    check(32'(n >= h + s + 2 && n <= h + s + 4), 32'h1);
    rd(8'h40);
    check(32'(d[2:0]), {29'h0, set, 1'b1});
    @(posedge core_clk);
    masterActive <= 1'b0;
    repeat (40) @(posedge core_clk);
    interfaceEnabled <= 1'b0;
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    t_regs();
    t_locked();
    for (int i = 0; i < 6; i++) begin
      wr(ofs[i], cnt[i]);
    end
    t_period(2'h1, 1'b0, 4, 3, 8'h00, 2'h0);
    t_period(2'h0, 1'b0, 4, 3, 8'h00, 2'h0);
    t_period(2'h2, 1'b0, 6, 5, 8'h00, 2'h1);
    t_period(2'h3, 1'b0, 2, 1, 8'h00, 2'h2);
    t_period(2'h3, 1'b1, 6, 5, 8'h00, 2'h1);
    t_period(2'h1, 1'b0, 4, 3, 8'h08, 2'h0);
    print_verdict();
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end
endmodule
